// File: rtl/asp_defs.svh
// Purpose: Constants for the asynchronous serial port
// Assumes: APB byte addresses, 32-bit data, 16-bit registers in low bits
// Notes:   Printed offsets are not all multiples of four, so they are indices
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define ASP_IDX_CTRL      10'h080
`define ASP_IDX_STAT      10'h082
`define ASP_IDX_TXD       10'h084
`define ASP_IDX_RXD       10'h086
`define ASP_IDX_DIV       10'h088
`define ASP_ADDR(i)       ({(i), 2'b00})

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define ASP_CT_DMA_HI     15
`define ASP_CT_DMA_LO     13
`define ASP_CT_TX_IRQ_ENABLE       11
`define ASP_CT_RX_IRQ_ENABLE       10
`define ASP_CT_LOOP       9
`define ASP_CT_BRK        8
`define ASP_CT_BREAK_LEVEL     7
`define ASP_CT_PEN        6
`define ASP_CT_PEVEN      5
`define ASP_CT_WLEN       4
`define ASP_CT_STP2       3
`define ASP_CT_TXEN       2
`define ASP_CT_RX_STATUS_IRQ_ENABLE       1
`define ASP_CT_RXEN       0
`define ASP_CT_RESET      16'h0000
`define ASP_CT_WMASK      16'hEFFF

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define ASP_ST_TRANSMITTER_IDLE_FLAG       6
`define ASP_ST_TX_HOLDING_EMPTY_FLAG       5
`define ASP_ST_RDR        4
`define ASP_ST_BREAK_DETECTED_FLAG       3
`define ASP_ST_FER        2
`define ASP_ST_PER        1
`define ASP_ST_OER        0
`define ASP_ST_ERRMASK    16'h000F

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ASP_OVS           6'd32
`define ASP_MID           5'd15
`define ASP_LAST          5'd31
`define ASP_DIV_RESET     16'h0000

`endif

// File: rtl/asp_pkg.sv
// Purpose: Types for the asynchronous serial port
// Assumes: Used with asp_defs.svh
// Notes:   States are one-hot
package asp_pkg;

    typedef enum logic [4:0] {
        ASP_IDLE   = 5'h01,
        ASP_START  = 5'h02,
        ASP_DATA   = 5'h04,
        ASP_PARITY = 5'h08,
        ASP_STOP   = 5'h10
    } asp_state_e;

endpackage : asp_pkg

// File: rtl/asp_serial_port.sv
// Purpose: Asynchronous serial port with APB register access
// Assumes: sys_clk 250 MHz, srst synchronous active high
// Notes:   Double-buffered receiver and transmitter, 32x oversampling
//
// Contract
// - Half-period of 32x clock is divisor+1 cycles
// - Receive shifter transfers into receive holding register
// - Rx ready bit4, cleared only by data read
// - Tx holding empty bit5, double buffered
// - Transmitter idle bit6: shifter and holding empty
// - Break received sets break flag bit3
// - Low stop bit sets framing flag bit2 unless the frame is a break
// - Parity mismatch sets parity flag bit1
// - Unread character replaced sets overrun bit0
// - Error flags sticky until software clears
// - Control bits 15:13 route DMA channels
// - Tx DMA requests on empty, masks tx irq
// - Rx DMA requests on ready, masks rx irq
// - Bit11 keeps tx irq while holding empty
// - Bit10 keeps rx irq while data valid
// - Bit1 enables receive status interrupt
// - Bit9 loops transmit back into receiver
// - Bit8 forces transmit pin to bit7
// - Bits 6:5 select none, odd, even parity
// - Bit4 eight data bits, bit3 two stops
// - Bit2 enables transmit, bit0 enables receive
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "asp_defs.svh"

module asp_serial_port (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    input  wire logic        serial_in_pin,
    output logic             serial_out_pin,
    output logic      [1:0]  dmaReqRx,
    output logic      [1:0]  dmaReqTx,
    output logic             txIrq,
    output logic             rxIrq,
    output logic             rxStatusIrq
);

    // ------------------------------------------------------------------
    // Registers and bus decode
    // ------------------------------------------------------------------
    logic [15:0] serialControl;
    logic [15:0] rateDivisorValue;
    logic [7:0]  txHolding;
    logic [7:0]  rxHolding;
    logic        txHoldingEmptyFlag;
    logic        rxReadyFlag;
    logic [3:0]  errFlags;
    logic        transmitterIdleFlag;
    logic        txBusy;
    logic        access;
    logic        wrCtrl;
    logic        wrStat;
    logic        wrTx;
    logic        wrDiv;
    logic        rdRx;
    logic        mapped;
    logic [15:0] statusWord;

    assign access  = psel && penable;
    assign pready  = 1'b1;
    assign wrCtrl  = access && pwrite && paddr == `ASP_ADDR(`ASP_IDX_CTRL);
    assign wrStat  = access && pwrite && paddr == `ASP_ADDR(`ASP_IDX_STAT);
    assign wrTx    = access && pwrite && paddr == `ASP_ADDR(`ASP_IDX_TXD);
    assign wrDiv   = access && pwrite && paddr == `ASP_ADDR(`ASP_IDX_DIV);
    assign rdRx    = access && !pwrite && paddr == `ASP_ADDR(`ASP_IDX_RXD);
    assign mapped  = paddr == `ASP_ADDR(`ASP_IDX_CTRL) || paddr == `ASP_ADDR(`ASP_IDX_STAT)
                  || paddr == `ASP_ADDR(`ASP_IDX_TXD) || paddr == `ASP_ADDR(`ASP_IDX_RXD)
                  || paddr == `ASP_ADDR(`ASP_IDX_DIV);
    assign pslverr = access && !mapped;

    assign transmitterIdleFlag = txHoldingEmptyFlag && !txBusy;
    always_comb begin
        statusWord = 16'h0000;
        statusWord[`ASP_ST_TRANSMITTER_IDLE_FLAG] = transmitterIdleFlag;
        statusWord[`ASP_ST_TX_HOLDING_EMPTY_FLAG] = txHoldingEmptyFlag;
        statusWord[`ASP_ST_RDR]  = rxReadyFlag;
        statusWord[`ASP_ST_BREAK_DETECTED_FLAG:`ASP_ST_OER] = errFlags;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `ASP_ADDR(`ASP_IDX_CTRL): prdata <= {16'h0000, serialControl};
                `ASP_ADDR(`ASP_IDX_STAT): prdata <= {16'h0000, statusWord};
                `ASP_ADDR(`ASP_IDX_TXD):  prdata <= {24'h000000, txHolding};
                `ASP_ADDR(`ASP_IDX_RXD):  prdata <= {24'h000000, rxHolding};
                `ASP_ADDR(`ASP_IDX_DIV):  prdata <= {16'h0000, rateDivisorValue};
                default:                  prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            serialControl <= `ASP_CT_RESET;
        end else if (wrCtrl) begin
            serialControl <= pwdata[15:0] & `ASP_CT_WMASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rateDivisorValue <= `ASP_DIV_RESET;
        end else if (wrDiv) begin
            rateDivisorValue <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------------
    // 32x sample tick
    // ------------------------------------------------------------------
    logic [15:0] halfCount;
    logic        halfPhase;
    logic        tick;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            halfCount <= 16'h0000;
            halfPhase <= 1'b0;
        end else if (halfCount >= rateDivisorValue) begin
            halfCount <= 16'h0000;
            halfPhase <= !halfPhase;
        end else begin
            halfCount <= halfCount + 16'h0001;
        end
    end
    assign tick = (halfCount >= rateDivisorValue) && halfPhase;

    // ------------------------------------------------------------------
    // Frame geometry: word length and parity for both directions, stop count for transmit only
    // ------------------------------------------------------------------
    logic [3:0] dataBits;
    logic       parityOn;
    logic       parityEven;
    logic [1:0] stopBits;
    assign dataBits   = serialControl[`ASP_CT_WLEN] ? 4'h8 : 4'h7;
    assign stopBits   = serialControl[`ASP_CT_STP2] ? 2'h2 : 2'h1;
    assign parityOn   = serialControl[`ASP_CT_PEN];
    assign parityEven = serialControl[`ASP_CT_PEVEN];

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    asp_pkg::asp_state_e txState;
    logic [7:0] txShift;
    logic [4:0] txSub;
    logic [3:0] txBit;
    logic       txPar;
    logic       txLine;
    logic       txEn;
    logic       txLoad;

    assign txEn   = serialControl[`ASP_CT_TXEN];
    assign txBusy = txState != asp_pkg::ASP_IDLE;
    assign txLoad = tick && txEn && !txBusy && !txHoldingEmptyFlag;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            txHolding <= 8'h00;
        end else if (wrTx) begin
            txHolding <= pwdata[7:0];  // overwrites if not empty
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            txHoldingEmptyFlag <= 1'b1;
        end else if (wrTx) begin
            txHoldingEmptyFlag <= 1'b0;
        end else if (txLoad) begin
            txHoldingEmptyFlag <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            txState <= asp_pkg::ASP_IDLE;
            txShift <= 8'h00;
            txSub   <= 5'h00;
            txBit   <= 4'h0;
            txPar   <= 1'b0;
            txLine  <= 1'b1;
        end else if (!txEn) begin
            txState <= asp_pkg::ASP_IDLE;
            txLine  <= 1'b1;
        end else if (tick) begin
            txSub <= txSub + 5'h01;
            case (txState)
                asp_pkg::ASP_IDLE: begin
                    txLine <= 1'b1;
                    if (!txHoldingEmptyFlag) begin
                        txShift <= txHolding;
                        txPar   <= !parityEven;
                        txSub   <= 5'h00;
                        txLine  <= 1'b0;
                        txState <= asp_pkg::ASP_START;
                    end
                end
                asp_pkg::ASP_START: begin
                    if (txSub == `ASP_LAST) begin
                        txLine  <= txShift[0];
                        txPar   <= txPar ^ txShift[0];
                        txShift <= {1'b0, txShift[7:1]};
                        txBit   <= 4'h1;
                        txState <= asp_pkg::ASP_DATA;
                    end
                end
                asp_pkg::ASP_DATA: begin
                    if (txSub == `ASP_LAST) begin
                        if (txBit < dataBits) begin
                            txLine  <= txShift[0];
                            txPar   <= txPar ^ txShift[0];
                            txShift <= {1'b0, txShift[7:1]};
                            txBit   <= txBit + 4'h1;
                        end else if (parityOn) begin
                            txLine  <= txPar;
                            txState <= asp_pkg::ASP_PARITY;
                        end else begin
                            txLine  <= 1'b1;
                            txBit   <= 4'h0;
                            txState <= asp_pkg::ASP_STOP;
                        end
                    end
                end
                asp_pkg::ASP_PARITY: begin
                    if (txSub == `ASP_LAST) begin
                        txLine  <= 1'b1;
                        txBit   <= 4'h0;
                        txState <= asp_pkg::ASP_STOP;
                    end
                end
                asp_pkg::ASP_STOP: begin
                    if (txSub == `ASP_LAST) begin
                        if (txBit + 4'h1 >= {2'b00, stopBits}) begin
                            txState <= asp_pkg::ASP_IDLE;
                        end else begin
                            txBit <= txBit + 4'h1;
                        end
                    end
                end
                default: txState <= asp_pkg::ASP_IDLE;
            endcase
        end
    end

    // Break forcing wins over the shifter; registered so the pin is a flop.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            serial_out_pin <= 1'b1;
        end else if (serialControl[`ASP_CT_BRK]) begin
            serial_out_pin <= serialControl[`ASP_CT_BREAK_LEVEL];
        end else begin
            serial_out_pin <= txLine;
        end
    end

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    logic       rxMeta;
    logic       rxSync;
    logic       rxLine;
    logic       rxEn;
    logic       rxArmed;
    asp_pkg::asp_state_e rxState;
    logic [7:0] rxShift;
    logic [4:0] rxSub;
    logic [3:0] rxBit;
    logic       rxPar;
    logic       rxAllZero;
    logic       rxDone;
    logic       rxBadPar;
    logic       rxBadStop;
    logic       rxBreak;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rxMeta <= 1'b1;
            rxSync <= 1'b1;
        end else begin
            rxMeta <= serial_in_pin;
            rxSync <= rxMeta;
        end
    end

    assign rxLine = serialControl[`ASP_CT_LOOP] ? serial_out_pin : rxSync;
    assign rxEn   = serialControl[`ASP_CT_RXEN];

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rxState   <= asp_pkg::ASP_IDLE;
            rxArmed   <= 1'b0;
            rxShift   <= 8'h00;
            rxSub     <= 5'h00;
            rxBit     <= 4'h0;
            rxPar     <= 1'b0;
            rxAllZero <= 1'b1;
            rxDone    <= 1'b0;
            rxBadPar  <= 1'b0;
            rxBadStop <= 1'b0;
            rxBreak   <= 1'b0;
        end else begin
            rxDone <= 1'b0;
            if (!rxEn) begin
                rxState <= asp_pkg::ASP_IDLE;
            end else if (tick) begin
                rxSub <= rxSub + 5'h01;
                case (rxState)
                    asp_pkg::ASP_IDLE: begin
                        // A start needs a fall, so a low stop or held break never restarts
                        rxArmed <= rxLine;
                        if (!rxLine && rxArmed) begin
                            rxSub   <= 5'h00;
                            rxState <= asp_pkg::ASP_START;
                        end
                    end
                    asp_pkg::ASP_START: begin
                        if (rxSub == `ASP_MID) begin
                            if (rxLine) begin
                                rxState <= asp_pkg::ASP_IDLE; // glitch
                            end else begin
                                rxSub     <= 5'h00;
                                rxBit     <= 4'h0;
                                rxPar     <= !parityEven;
                                rxAllZero <= 1'b1;
                                rxBadPar  <= 1'b0;
                                rxShift   <= 8'h00;
                                rxState   <= asp_pkg::ASP_DATA;
                            end
                        end
                    end
                    asp_pkg::ASP_DATA: begin
                        if (rxSub == `ASP_LAST) begin
                            rxShift   <= (dataBits == 4'h8) ? {rxLine, rxShift[7:1]}
                                                            : {1'b0, rxLine, rxShift[6:1]};
                            rxPar     <= rxPar ^ rxLine;
                            rxAllZero <= rxAllZero && !rxLine;
                            rxBit     <= rxBit + 4'h1;
                            if (rxBit + 4'h1 == dataBits) begin
                                rxState <= parityOn ? asp_pkg::ASP_PARITY
                                                    : asp_pkg::ASP_STOP;
                            end
                        end
                    end
                    asp_pkg::ASP_PARITY: begin
                        if (rxSub == `ASP_LAST) begin
                            rxBadPar  <= rxPar != rxLine;
                            rxAllZero <= rxAllZero && !rxLine;
                            rxState   <= asp_pkg::ASP_STOP;
                        end
                    end
                    asp_pkg::ASP_STOP: begin
                        // Only the first stop bit is checked, so frames may abut.
                        if (rxSub == `ASP_LAST) begin
                            rxBadStop <= !rxLine;
                            rxBreak   <= rxAllZero && !rxLine;
                            rxDone    <= 1'b1;
                            rxState   <= asp_pkg::ASP_IDLE;
                        end
                    end
                    default: rxState <= asp_pkg::ASP_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rxHolding <= 8'h00;
        end else if (rxDone) begin
            rxHolding <= rxShift;
        end
    end

    // Set wins over a same-cycle read so no character is lost.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rxReadyFlag <= 1'b0;
        end else if (rxDone) begin
            rxReadyFlag <= 1'b1;
        end else if (rdRx) begin
            rxReadyFlag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Sticky error flags: write 1 to the status word clears a flag
    // ------------------------------------------------------------------
    logic [3:0] errSet;
    assign errSet = {rxDone && rxBreak, rxDone && rxBadStop && !rxBreak,
                     rxDone && rxBadPar, rxDone && rxReadyFlag && !rdRx};

    generate
        for (genvar i = 0; i < 4; i++) begin : g_err
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    errFlags[i] <= 1'b0;
                end else if (errSet[i]) begin
                    errFlags[i] <= 1'b1;
                end else if (wrStat && pwdata[i]) begin
                    errFlags[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // DMA routing and interrupt requests
    // ------------------------------------------------------------------
    logic [1:0] rxRoute;
    logic [1:0] txRoute;
    always_comb begin
        rxRoute = 2'b00;
        txRoute = 2'b00;
        case (serialControl[`ASP_CT_DMA_HI:`ASP_CT_DMA_LO])
            3'h1: begin rxRoute = 2'b01; txRoute = 2'b10; end
            3'h2: begin rxRoute = 2'b10; txRoute = 2'b01; end
            3'h4: rxRoute = 2'b01;
            3'h5: rxRoute = 2'b10;
            3'h6: txRoute = 2'b01;
            3'h7: txRoute = 2'b10;
            default: rxRoute = 2'b00;
        endcase
    end

    assign dmaReqTx = txRoute & {2{txHoldingEmptyFlag}};
    assign dmaReqRx = rxRoute & {2{rxReadyFlag}};
    assign txIrq = serialControl[`ASP_CT_TX_IRQ_ENABLE] && txHoldingEmptyFlag
                && txRoute == 2'b00;
    assign rxIrq = serialControl[`ASP_CT_RX_IRQ_ENABLE] && rxReadyFlag
                && rxRoute == 2'b00;
    assign rxStatusIrq = serialControl[`ASP_CT_RX_STATUS_IRQ_ENABLE] && (errFlags != 4'h0);

endmodule : asp_serial_port

// File: bench/asp_serial_port_chk.sv
// Purpose: Checker for the serial port, bound to its top module
// Assumes: Control shadow is built from APB writes seen at the ports
// Notes:   Status is not visible at the ports, so gates are one-sided
`timescale 1ns/1ps
`include "asp_defs.svh"
module asp_serial_port_chk (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        serial_in_pin,
    input wire logic        serial_out_pin,
    input wire logic [1:0]  dmaReqRx,
    input wire logic [1:0]  dmaReqTx,
    input wire logic        txIrq,
    input wire logic        rxIrq,
    input wire logic        rxStatusIrq
);
    logic [15:0] ctl;
    logic        txDma;
    logic        rxDma;
    logic        acc;
    always_ff @(posedge sys_clk) begin
        if (srst) ctl <= 16'h0000;
        else if (acc && pwrite && paddr == 12'h200) ctl <= pwdata[15:0] & `ASP_CT_WMASK;
    end
    assign acc   = psel && penable;
    assign txDma = ctl[15:13] inside {3'h1, 3'h2, 3'h6, 3'h7};
    assign rxDma = ctl[15:13] inside {3'h1, 3'h2, 3'h4, 3'h5};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    a_apb_ready: assert property (psel |-> pready) else $error("pready low");
    a_slverr_unmapped: assert property (acc && !(paddr inside {12'h200, 12'h208, 12'h210,
        12'h218, 12'h220}) |-> pslverr) else $error("no slave error");
    a_slverr_mapped: assert property (acc && paddr == 12'h208 |-> !pslverr)
        else $error("slave error on status");
    a_txirq_gate: assert property (txIrq |-> ctl[11] && !txDma) else $error("tx irq");
    a_rxirq_gate: assert property (rxIrq |-> ctl[10] && !rxDma) else $error("rx irq");
    a_status_irq: assert property (rxStatusIrq |-> ctl[1]) else $error("status irq");
    a_dma_tx_route: assert property (dmaReqTx != 2'b00 |-> txDma &&
        dmaReqTx == (ctl[13] ? 2'b10 : 2'b01)) else $error("tx dma route");
    a_dma_rx_route: assert property (dmaReqRx != 2'b00 |-> rxDma &&
        dmaReqRx == ((ctl[15] ? ctl[13] : ctl[14]) ? 2'b10 : 2'b01)) else $error("rx dma");
    a_break_force: assert property (ctl[8] && $stable(ctl) |-> serial_out_pin == ctl[7])
        else $error("break level");
    c_tx_irq: cover property (txIrq);
    c_rx_dma: cover property (dmaReqRx != 2'b00);
    c_status_irq: cover property (rxStatusIrq);
endmodule : asp_serial_port_chk

bind asp_serial_port asp_serial_port_chk u_asp_serial_port_chk (.*);

// File: bench/asp_remote.sv
// Purpose: Remote serial device facing the port's line pair
// Assumes: BIT processor cycles per bit; caller waits for whole frames
// Notes:   Receive line idles high, as the pin's pull-up would hold it
`timescale 1ns/1ps
module asp_remote #(parameter int BIT = 128) (
    input  wire logic clk,
    input  wire logic txLine,
    output logic      rxLine
);
    initial rxLine = 1'b1;
    // Low start, bits LSB first, then stop level, then idle high
    task automatic send(input logic [8:0] bits, input int n, input logic stopLvl);
        @(posedge clk);
        rxLine <= 1'b0;
        repeat (BIT) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rxLine <= bits[i];
            repeat (BIT) @(posedge clk);
        end
        rxLine <= stopLvl;
        repeat (BIT) @(posedge clk);
        rxLine <= 1'b1;
        repeat (BIT) @(posedge clk);
    endtask : send
    // Samples mid-bit, so a wrong bit time shows up as a wrong character
    task automatic recv(output logic [7:0] d);
        d = 8'h00;
        while (txLine !== 1'b0) @(posedge clk);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            d[i] = txLine;
        end
    endtask : recv
endmodule : asp_remote

// File: bench/tb_top.sv
// Purpose: Register-level tests of the serial port against a remote device
// Assumes: Divisor 1 gives 4-cycle ticks and 128-cycle bits
// Notes:   Port outputs are checked at the falling edge, once settled
`timescale 1ns/1ps
module tb_top;
    localparam logic [11:0] A_CTL = 12'h200, A_STS = 12'h208, A_TX = 12'h210, A_RX = 12'h218;
    logic        sys_clk, srst, psel, penable, pwrite, pready, pslverr, txPin, rxPin, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  dmaReqRx, dmaReqTx;
    logic        txIrq, rxIrq, rxStatusIrq;
    logic [7:0]  got;
    int          miscompares = 0;
    int          cmp_count = 0;
    asp_serial_port u_asp_serial_port (.*, .serial_in_pin(rxPin), .serial_out_pin(txPin));
    asp_remote #(.BIT(128)) u_asp_remote (.clk(sys_clk), .txLine(txPin), .rxLine(rxPin));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {16'h0000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp,
                       input string what);
        apb(1'b0, a, 16'h0000);
        chk(rd & mask, exp, what);
    endtask : rdc
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (60000) @(posedge sys_clk);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 3'b000, 12'h000, 32'h0};
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        rdc(A_CTL, 32'hFFFF_FFFF, 32'h0, "control reset");
        rdc(A_STS, 32'hFFFF_FFFF, 32'h60, "status reset");
        apb(1'b0, 12'h3FC, 16'h0000);
        chk({31'h0, err}, 32'h1, "unmapped error");
        apb(1'b1, 12'h220, 16'h0001);
        apb(1'b1, A_CTL, 16'h0015);
        apb(1'b1, A_TX, 16'h00A5);
        u_asp_remote.recv(got);
        chk({24'h0, got}, 32'hA5, "sent char");
        repeat (400) @(posedge sys_clk);
        rdc(A_STS, 32'hFFFF_FFFF, 32'h60, "tx idle");
        u_asp_remote.send(9'h03C, 8, 1'b1);
        rdc(A_STS, 32'hFFFF_FFFF, 32'h70, "rx ready");
        apb(1'b1, A_CTL, 16'h0415);
        @(negedge sys_clk);
        chk({31'h0, rxIrq}, 32'h1, "rx irq");
        apb(1'b1, A_CTL, 16'h8415);
        @(negedge sys_clk);
        chk({29'h0, rxIrq, dmaReqRx}, 32'h1, "rx dma");
        rdc(A_RX, 32'hFFFF_FFFF, 32'h3C, "rx data");
        rdc(A_STS, 32'hFFFF_FFFF, 32'h60, "rx read clears");
        $display("test basic done");
        apb(1'b1, A_CTL, 16'h0017);
        u_asp_remote.send(9'h080, 8, 1'b0);
        @(negedge sys_clk);
        chk({31'h0, rxStatusIrq}, 32'h1, "status irq");
        rdc(A_STS, 32'hF, 32'h4, "framing");
        rdc(A_RX, 32'h0, 32'h0, "drain");
        rdc(A_STS, 32'hF, 32'h4, "framing sticky");
        apb(1'b1, A_STS, 16'h000F);
        u_asp_remote.send(9'h000, 8, 1'b0);
        rdc(A_STS, 32'hF, 32'h8, "break");
        rdc(A_RX, 32'hFFFF_FFFF, 32'h0, "break data");
        apb(1'b1, A_STS, 16'h000F);
        apb(1'b1, A_CTL, 16'h0077);
        u_asp_remote.send(9'h001, 9, 1'b1);
        rdc(A_STS, 32'hF, 32'h2, "parity");
        apb(1'b1, A_STS, 16'h000F);
        apb(1'b1, A_CTL, 16'h0017);
        u_asp_remote.send(9'h011, 8, 1'b1);
        u_asp_remote.send(9'h022, 8, 1'b1);
        rdc(A_STS, 32'hF, 32'h1, "overrun");
        rdc(A_RX, 32'hFFFF_FFFF, 32'h22, "overrun data");
        apb(1'b1, A_STS, 16'h000F);
        rdc(A_STS, 32'hFFFF_FFFF, 32'h60, "cleared");
        $display("test errors done");
        apb(1'b1, A_CTL, 16'h0117);
        repeat (2) @(negedge sys_clk);
        chk({31'h0, txPin}, 32'h0, "break low");
        apb(1'b1, A_CTL, 16'hC984);
        repeat (2) @(negedge sys_clk);
        chk({29'h0, txIrq, dmaReqTx}, 32'h1, "tx dma");
        chk({31'h0, txPin}, 32'h1, "break high");
        apb(1'b1, A_CTL, 16'h0804);
        @(negedge sys_clk);
        chk({31'h0, txIrq}, 32'h1, "tx irq");
        apb(1'b1, A_CTL, 16'h0215);
        apb(1'b1, A_TX, 16'h005A);
        repeat (1800) @(posedge sys_clk);
        rdc(A_RX, 32'hFFFF_FFFF, 32'h5A, "loop back");
        $display("test control done");
        tally_and_finish();
    end
endmodule : tb_top
